// ==== shared/gpio_port_pkg.sv ====
// constants and carrier types for the dual general pin port
// assumes a 16-bit register port with word offsets and a single 125 MHz clock
package gpio_port_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] PORT_ONE_CONTROL_OFS = 8'h40;
    localparam logic [ADDR_W-1:0] PORT_TWO_CONTROL_OFS = 8'h41;
    // control field positions
    localparam int OUT_VALUE_BIT = 5;
    localparam int DRIVE_ENABLE_BIT = 4;
    localparam int CAPTURE_BIT = 3;
    localparam int CAPTURE_CLEAR_BIT = 2;
    localparam int INVERT_OR_FALLING_BIT = 1;
    localparam int EDGE_MODE_BIT = 0;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
    // qualification time: four oscillator periods at 8 ns
    localparam int CLK_PERIOD_PS = 8000;
    localparam int QUALIFY_TIME_PS = 32000;
    localparam int QUALIFY_CYCLES = (QUALIFY_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int QCNT_W = 3;
    localparam int NUM_CHAN = 2;

    // software-held control fields of one channel
    typedef struct packed {
        logic out_value;
        logic drive_enable;
        logic capture_clear;
        logic invert_or_falling;
        logic edge_mode;
    } chan_ctrl_s;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
endpackage : gpio_port_pkg

// ==== testbench/pin_source.sv ====
// far-side model of one general pin: an external source beside the port's driver
// assumes the bench sets the external level and holds it for whole cycles
`timescale 1ns/1ps
module pin_source
(
    input wire logic ext_level,
    input wire logic drv_value,
    input wire logic drv_enable,
    output logic pin_level
);
    // the port's driver overrides the weak external source while enabled
    assign pin_level = drv_enable ? drv_value : ext_level;
endmodule : pin_source

// ==== testbench/test_dual_general_io_port.sv ====
// self-checking bench for the dual general pin port
// assumes pin_source resolves each pin from the port driver and a bench level
`timescale 1ns/1ps
module test_dual_general_io_port;
    import gpio_port_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] rdv;
    logic [1:0] ext = 2'b00;
    wire logic [1:0] pin;
    wire logic [1:0] pout;
    wire logic [1:0] poe;
    bit [31:0] seed = 34;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int ctrl[2] = '{0, 0};
    int cap[2] = '{0, 0};

    dual_general_io_port u_dual_general_io_port (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .general_pin_one_in(pin[0]), .general_pin_one_out(pout[0]), .general_pin_one_oe(poe[0]),
        .general_pin_two_in(pin[1]), .general_pin_two_out(pout[1]), .general_pin_two_oe(poe[1]));
    pin_source u_pin_one (.ext_level(ext[0]), .drv_value(pout[0]), .drv_enable(poe[0]), .pin_level(pin[0]));
    pin_source u_pin_two (.ext_level(ext[1]), .drv_value(pout[1]), .drv_enable(poe[1]), .pin_level(pin[1]));

    // free-running clock and a hang guard well above the expected run
    always #4 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            summarize();
        end
    end

    function int xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed);
    endfunction : xs

    // model view of a control word; level mode tracks the resolved pin
    function logic [15:0] expw(input int ch);
        int c;
        int p;
        c = ctrl[ch] & 'h37;
        p = ((c >> 4) & 1) ? ((c >> 5) & 1) : int'(ext[ch]);
        if ((c & 1) == 0)
            cap[ch] = ((c >> 2) & 1) ? 0 : (p ^ ((c >> 1) & 1));
        return 16'(c | (cap[ch] << 3));
    endfunction : expw

    task check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wr(input int ch, input int d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= 8'(8'h40 + ch);
        reg_wdata <= 16'(d);
        ctrl[ch] = d;
        if (d & 4)
            cap[ch] = 0;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task rd(input int a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= 8'(a);
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
    endtask : rd

    // level lasts hold cycles when the next call follows at once; under four is ignored
    task set_pin(input int ch, input int v, input int hold);
        int c;
        c = ctrl[ch];
        if ((c & 1) && !(c & 4) && hold >= 4 && v != ext[ch] && v == (((c >> 1) & 1) ^ 1))
            cap[ch] = 1;
        @(posedge mclk);
        ext[ch] <= v[0];
        repeat (hold - 1) @(posedge mclk);
    endtask : set_pin

    task summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        rd(8'h42);
        check(rdv, 16'h0000);
        // random drive bits and upper junk, level mode, writes one idle cycle apart
        for (int i = 0; i < 6; i++)
        begin
            ext <= 2'(xs());
            wr(0, xs() & 'hFFF0);
            wr(1, xs() & 'hFFF0);
            repeat (12) @(posedge mclk);
            #1;
            for (int ch = 0; ch < 2; ch++)
            begin
                check(16'({pout[ch], poe[ch]}), 16'((ctrl[ch] >> 4) & 3));
                rd(8'h40 + ch);
                check(rdv, expw(ch));
            end
        end
        for (int ch = 0; ch < 2; ch++)
        begin
            // level mode with and without inversion
            for (int k = 0; k < 4; k++)
            begin
                wr(ch, (k >> 1) << 1);
                set_pin(ch, k & 1, 12);
                rd(8'h40 + ch);
                check(rdv, expw(ch));
            end
            wr(ch, 4);
            set_pin(ch, 1, 12);
            rd(8'h40 + ch);
            check(rdv, expw(ch));
            wr(ch, 0);
            repeat (12) @(posedge mclk);
            rd(8'h40 + ch);
            check(rdv, expw(ch));
            // edge mode, both polarities
            for (int p = 0; p < 2; p++)
            begin
                wr(ch, 5 | (p << 1));
                set_pin(ch, 1 - p, 12);
                set_pin(ch, p, 12);
                set_pin(ch, 1 - p, 12);
                wr(ch, 1 | (p << 1));
                rd(8'h40 + ch);
                check(rdv, expw(ch));
                set_pin(ch, p, 12);
                rd(8'h40 + ch);
                check(rdv, expw(ch));
                set_pin(ch, 1 - p, 3);
                set_pin(ch, p, 12);
                rd(8'h40 + ch);
                check(rdv, expw(ch));
                set_pin(ch, 1 - p, 4);
                set_pin(ch, p, 12);
                rd(8'h40 + ch);
                check(rdv, expw(ch));
                wr(ch, 5 | (p << 1));
                rd(8'h40 + ch);
                check(rdv, expw(ch));
            end
        end
        summarize();
    end
endmodule : test_dual_general_io_port

// ==== verilog/dual_general_io_port.sv ====
// two general pin channels, each with one 16-bit control register
// assumes a one-cycle register port and pins asynchronous to mclk
// Functional notes
// - enabled driver puts bit 5 onto pin
// - bit 4 enables driver, else three-state
// - level mode: capture bit tracks pin
// - edge mode: selected edge sets capture
// - clear bit forces capture to zero
// - level mode: bit 1 inverts sampled level
// - edge mode: bit 1 selects falling edge
// - bit 0 selects edge or level mode
// - pin must persist four periods to count
// - level tracking suspended while clear set
// - edge detection disarmed while clear set
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module dual_general_io_port
    import gpio_port_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic general_pin_one_in,
    output logic general_pin_one_out,
    output logic general_pin_one_oe,
    input wire logic general_pin_two_in,
    output logic general_pin_two_out,
    output logic general_pin_two_oe
);
    reg_req_s req;
    chan_ctrl_s ctrl_q [NUM_CHAN];
    logic [NUM_CHAN-1:0] capture_q;
    logic [NUM_CHAN-1:0] level_q;
    logic [NUM_CHAN-1:0] prev_q;
    logic [NUM_CHAN-1:0] pins_in;
    logic [NUM_CHAN-1:0] addr_sel;

    // channel index decode, used by write and read paths
    function automatic logic [NUM_CHAN-1:0] chan_sel(input logic [ADDR_W-1:0] a);
        chan_sel = {a == PORT_TWO_CONTROL_OFS, a == PORT_ONE_CONTROL_OFS};
    endfunction : chan_sel

    // pack a channel into its register image, upper bits zero
    function automatic logic [DATA_W-1:0] image(input chan_ctrl_s c, input logic cap);
        logic [DATA_W-1:0] v;
        v = '0;
        v[OUT_VALUE_BIT] = c.out_value;
        v[DRIVE_ENABLE_BIT] = c.drive_enable;
        v[CAPTURE_BIT] = cap;
        v[CAPTURE_CLEAR_BIT] = c.capture_clear;
        v[INVERT_OR_FALLING_BIT] = c.invert_or_falling;
        v[EDGE_MODE_BIT] = c.edge_mode;
        image = v;
    endfunction : image

    // bundle the port request so both channels see one carrier
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign pins_in = {general_pin_two_in, general_pin_one_in};

    // one decode shared by the read mux and the pin assertions
    assign addr_sel = chan_sel(req.addr);

    // pin drivers straight from control flops
    assign general_pin_one_out = ctrl_q[0].out_value;
    assign general_pin_one_oe = ctrl_q[0].drive_enable;
    assign general_pin_two_out = ctrl_q[1].out_value;
    assign general_pin_two_oe = ctrl_q[1].drive_enable;

    // per-channel control, qualifier, edge detect and capture
    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++)
        begin : g_chan
            logic edge_hit;
            logic [NUM_CHAN-1:0] sel;

            pin_qualifier u_qual (
                .mclk(mclk),
                .nrst(nrst),
                .pin_in(pins_in[g]),
                .level_q(level_q[g])
            );

            assign sel = chan_sel(req.addr);

            // control fields; capture bit is hardware-owned, bits above 5 dropped
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                begin
                    ctrl_q[g] <= '0;
                end
                else if (req.wr && sel[g])
                begin
                    ctrl_q[g].out_value <= req.wdata[OUT_VALUE_BIT];
                    ctrl_q[g].drive_enable <= req.wdata[DRIVE_ENABLE_BIT];
                    ctrl_q[g].capture_clear <= req.wdata[CAPTURE_CLEAR_BIT];
                    ctrl_q[g].invert_or_falling <= req.wdata[INVERT_OR_FALLING_BIT];
                    ctrl_q[g].edge_mode <= req.wdata[EDGE_MODE_BIT];
                end
            end

            // previous qualified level for edge detection
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                begin
                    prev_q[g] <= 1'b0;
                end
                else
                begin
                    prev_q[g] <= level_q[g];
                end
            end

            // falling when bit 1 set, rising otherwise
            assign edge_hit = ctrl_q[g].invert_or_falling ? (prev_q[g] && !level_q[g])
                                                          : (!prev_q[g] && level_q[g]);

            // capture bit: clear wins while held, edges stay disarmed meanwhile
            // clear beating a same-cycle edge keeps a held clear from leaking a 1
            always_ff @(posedge mclk or negedge nrst)
            begin
                if (!nrst)
                begin
                    capture_q[g] <= 1'b0;
                end
                else if (ctrl_q[g].capture_clear)
                begin
                    capture_q[g] <= 1'b0;
                end
                else if (!ctrl_q[g].edge_mode)
                begin
                    capture_q[g] <= level_q[g] ^ ctrl_q[g].invert_or_falling;
                end
                else if (edge_hit)
                begin
                    capture_q[g] <= 1'b1;
                end
            end

            // clear seen on two edges in a row
            sequence s_clear_held;
                ctrl_q[g].capture_clear ##1 ctrl_q[g].capture_clear;
            endsequence

            // a held clear has already zeroed the capture bit
            property p_clear_forces;
                @(posedge mclk) disable iff (!nrst)
                s_clear_held |-> !capture_q[g];
            endproperty
            a_clear_forces: assert property (p_clear_forces) else $error("capture not cleared");

            // level mode follows the qualified pin, xor the invert bit
            property p_level_track;
                @(posedge mclk) disable iff (!nrst)
                (!ctrl_q[g].edge_mode && !ctrl_q[g].capture_clear)
                    |=> capture_q[g] == ($past(level_q[g]) ^ $past(ctrl_q[g].invert_or_falling));
            endproperty
            a_level_track: assert property (p_level_track) else $error("level tracking wrong");

            // a caught edge stays caught until clear
            property p_edge_sticky;
                @(posedge mclk) disable iff (!nrst)
                (ctrl_q[g].edge_mode && !ctrl_q[g].capture_clear && capture_q[g]
                    && !(req.wr && sel[g])) |=> capture_q[g];
            endproperty
            a_edge_sticky: assert property (p_edge_sticky) else $error("edge capture lost");

            // an armed selected edge sets the capture bit
            property p_edge_set;
                @(posedge mclk) disable iff (!nrst)
                (ctrl_q[g].edge_mode && !ctrl_q[g].capture_clear && edge_hit) |=> capture_q[g];
            endproperty
            a_edge_set: assert property (p_edge_set) else $error("edge not captured");

            // rising mode ignores falling edges and quiet input
            property p_rise_only;
                @(posedge mclk) disable iff (!nrst)
                (ctrl_q[g].edge_mode && !ctrl_q[g].invert_or_falling && !capture_q[g]
                    && !ctrl_q[g].capture_clear && !(prev_q[g] == 1'b0 && level_q[g] == 1'b1))
                    |=> !capture_q[g] || $past(req.wr);
            endproperty
            a_rise_only: assert property (p_rise_only) else $error("capture without rising edge");

            // edges are ignored while clear is held
            property p_disarmed;
                @(posedge mclk) disable iff (!nrst)
                (ctrl_q[g].capture_clear && ctrl_q[g].edge_mode && !(req.wr && sel[g])) |=> !capture_q[g];
            endproperty
            a_disarmed: assert property (p_disarmed) else $error("edge armed while clear held");

            // falling mode ignores rising edges and quiet input
            property p_fall_only;
                @(posedge mclk) disable iff (!nrst)
                (ctrl_q[g].edge_mode && ctrl_q[g].invert_or_falling && !capture_q[g]
                    && !ctrl_q[g].capture_clear && !(prev_q[g] && !level_q[g])) |=> !capture_q[g];
            endproperty
            a_fall_only: assert property (p_fall_only) else $error("capture without falling edge");

            // inverted level mode stores the complement
            property p_invert;
                @(posedge mclk) disable iff (!nrst)
                (!ctrl_q[g].edge_mode && !ctrl_q[g].capture_clear && ctrl_q[g].invert_or_falling)
                    |=> capture_q[g] == !$past(level_q[g]);
            endproperty
            a_invert: assert property (p_invert) else $error("inverted level wrong");

            // level tracking held off while clear stays set
            property p_level_off;
                @(posedge mclk) disable iff (!nrst)
                (ctrl_q[g].capture_clear && !ctrl_q[g].edge_mode) |=> !capture_q[g];
            endproperty
            a_level_off: assert property (p_level_off) else $error("tracking while clear held");

            // a read returns this channel's mode and capture bits
            property p_read_image;
                @(posedge mclk) disable iff (!nrst)
                (req.rd && sel[g]) |=> reg_rdata[CAPTURE_BIT] == $past(capture_q[g])
                    && reg_rdata[EDGE_MODE_BIT] == $past(ctrl_q[g].edge_mode);
            endproperty
            a_read_image: assert property (p_read_image) else $error("read image wrong");

            // writing the clear bit zeroes capture two edges later
            property p_clear_write;
                @(posedge mclk) disable iff (!nrst)
                (req.wr && sel[g] && req.wdata[CAPTURE_CLEAR_BIT]) |=> ##1 !capture_q[g];
            endproperty
            a_clear_write: assert property (p_clear_write) else $error("clear write ignored");
        end
    endgenerate

    // read data registered, valid only in cycle after strobe
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rdata <= CTRL_RESET;
        end
        else if (req.rd)
        begin
            unique case (1'b1)
                addr_sel[0]: reg_rdata <= image(ctrl_q[0], capture_q[0]);
                addr_sel[1]: reg_rdata <= image(ctrl_q[1], capture_q[1]);
                default: reg_rdata <= CTRL_RESET; // unmapped reads zero
            endcase
        end
        else
        begin
            reg_rdata <= CTRL_RESET;
        end
    end

    // pin one only moves after a write to its own register
    property p_drive;
        @(posedge mclk) disable iff (!nrst)
        !(req.wr && addr_sel[0]) |=> $stable(general_pin_one_out) && $stable(general_pin_one_oe);
    endproperty
    a_drive: assert property (p_drive) else $error("pin one drive moved without write");

    // same for pin two
    property p_drive_two;
        @(posedge mclk) disable iff (!nrst)
        !(req.wr && addr_sel[1]) |=> $stable(general_pin_two_out) && $stable(general_pin_two_oe);
    endproperty
    a_drive_two: assert property (p_drive_two) else $error("pin two drive moved without write");

    // a write to channel one lands on its pin in the next cycle
    property p_write_one;
        @(posedge mclk) disable iff (!nrst)
        (req.wr && addr_sel[0]) |=> general_pin_one_out == $past(req.wdata[OUT_VALUE_BIT])
            && general_pin_one_oe == $past(req.wdata[DRIVE_ENABLE_BIT]);
    endproperty
    a_write_one: assert property (p_write_one) else $error("pin one write not applied");

    // and likewise on channel two
    property p_write_two;
        @(posedge mclk) disable iff (!nrst)
        (req.wr && addr_sel[1]) |=> general_pin_two_out == $past(req.wdata[OUT_VALUE_BIT])
            && general_pin_two_oe == $past(req.wdata[DRIVE_ENABLE_BIT]);
    endproperty
    a_write_two: assert property (p_write_two) else $error("pin two write not applied");

    // unmapped addresses read back as zero
    property p_unmapped_zero;
        @(posedge mclk) disable iff (!nrst)
        (req.rd && addr_sel == '0) |=> reg_rdata == '0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    // upper field stays zero on every read
    property p_upper_zero;
        @(posedge mclk) disable iff (!nrst)
        $past(req.rd) |-> reg_rdata[DATA_W-1:OUT_VALUE_BIT+1] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");
endmodule : dual_general_io_port

// ==== verilog/pin_qualifier.sv ====
// synchroniser and four-period filter for one input pin
// assumes the pin is asynchronous to mclk
`timescale 1ns/1ps
module pin_qualifier
    import gpio_port_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic pin_in,
    output logic level_q
);
    logic sync1_q;
    logic sync2_q;
    logic cand_q;
    logic [QCNT_W-1:0] cnt_q;

    // two-flop synchroniser; only sync2 reads sync1
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    // a new level must persist before it is accepted
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            cand_q <= 1'b0;
            cnt_q <= 3'h0;
            level_q <= 1'b0;
        end
        else if (sync2_q != cand_q)
        begin
            cand_q <= sync2_q;
            cnt_q <= 3'h1;
        end
        // accept on the fourth equal sample, so a pulse of exactly four periods counts
        else if (cnt_q < QCNT_W'(QUALIFY_CYCLES - 1))
        begin
            cnt_q <= cnt_q + 3'h1;
        end
        else
        begin
            level_q <= cand_q;
        end
    end

    property p_qual_stable;
        @(posedge mclk) disable iff (!nrst)
        $changed(level_q) |-> $past(sync2_q, 1) == level_q && $past(sync2_q, 4) == level_q;
    endproperty
    a_qual_stable: assert property (p_qual_stable) else $error("level accepted without four stable cycles");
endmodule : pin_qualifier
